// ### logic/cit_pkg.sv
// Package: constants and types for the instruction timing sequencer
package cit_pkg;
	typedef logic [1:0] cit_len_t;
	typedef logic [2:0] cit_cyc_t;

	// Special function register address and reset value of the stack pointer
	localparam logic [7:0] CIT_SP_ADDR = 8'h81;
	localparam logic [7:0] CIT_SP_RESET = 8'h07;

	localparam int CIT_NUM_BP = 4;
	localparam int CIT_CNT_W = 32;
	localparam int CIT_PC_W = 16;

	// Byte length per opcode: one 32-bit word per low-nibble column
	// (0..5, then @Ri, then Rn), two bits per high nibble, LSB first
	localparam logic [31:0] CIT_LEN_TBL [0:7] = '{
		32'h5AAE_AAFD, 32'hAAAA_AAAA, 32'h5AAA_AA5F, 32'h5555_7F55,
		32'h55D9_AAA5, 32'hAEDB_EAAA, 32'h55E6_9555, 32'h59E6_9555
	};

	// Cycle counts that differ from the byte length
	localparam cit_cyc_t CIT_CYC_SWAP_IND = 3'h2;
	localparam cit_cyc_t CIT_CYC_ABS = 3'h3;
	localparam cit_cyc_t CIT_CYC_LONG = 3'h4;
	localparam cit_cyc_t CIT_CYC_RETURN = 3'h5;
	localparam cit_cyc_t CIT_CYC_JUMP_IND = 3'h3;
	localparam cit_cyc_t CIT_CYC_CMP_IND = 3'h4;
	localparam cit_cyc_t CIT_TAKEN_EXTRA = 3'h1;

	localparam logic [7:0] CIT_OP_BIT_SET_CLEAR = 8'h10;

	// Taken conditional branch runs one cycle longer than untaken
	function automatic cit_cyc_t cit_total(input cit_cyc_t base, input logic taken);
		cit_total = taken ? cit_cyc_t'(base + CIT_TAKEN_EXTRA) : base;
	endfunction
endpackage

// ### logic/cit_if.sv
// Interfaces: decoder lookup and debug control links inside the core
`timescale 1ns/10ps
interface cit_dec_if;
	import cit_pkg::*;
	logic [7:0] opcode;
	cit_len_t len;
	cit_cyc_t cyc;
	logic cond;
	logic bit_clear;
	modport core (output opcode, input len, cyc, cond, bit_clear);
	modport dec (input opcode, output len, cyc, cond, bit_clear);
endinterface

interface cit_dbg_if #(
	parameter int NUM_BP = 4,
	parameter int IDX_W = (NUM_BP > 1) ? $clog2(NUM_BP) : 1
);
	logic halt_req;
	logic run_req;
	logic step_req;
	logic bp_wr;
	logic [IDX_W-1:0] bp_index;
	logic [15:0] bp_addr;
	logic bp_enable;
	logic fetch_valid;
	logic [15:0] fetch_addr;
	logic accept;
	logic permit;
	logic halted;
	logic bp_hit;
	modport core (output halt_req, run_req, step_req, bp_wr, bp_index, bp_addr, bp_enable,
		fetch_valid, fetch_addr, accept, input permit, halted, bp_hit);
	modport ctl (input halt_req, run_req, step_req, bp_wr, bp_index, bp_addr, bp_enable,
		fetch_valid, fetch_addr, accept, output permit, halted, bp_hit);
endinterface

// ### logic/cit_opcode_decode.sv
// Opcode decoder: byte length, base cycle count and branch class
`timescale 1ns/10ps
module cit_opcode_decode
	import cit_pkg::*;
(
	cit_dec_if.dec dec
);
	logic [2:0] col;
	logic [7:0] op;

	always_comb begin
		op = dec.opcode;
		col = (op[3:0] > 4'h7) ? 3'h7 : ((op[3:0] > 4'h5) ? 3'h6 : op[2:0]);
		// Encodings follow the standard set unchanged
		dec.len = CIT_LEN_TBL[col][{op[7:4], 1'b0} +: 2];
		dec.cyc = {1'b0, dec.len};
		dec.cond = 1'b0;
		dec.bit_clear = (op == CIT_OP_BIT_SET_CLEAR);
		if (op[3:0] == 4'h1) begin
			dec.cyc = CIT_CYC_ABS;
		end
		unique case (op) inside
			8'h02, 8'h12: dec.cyc = CIT_CYC_LONG;
			8'h80: dec.cyc = CIT_CYC_ABS;
			8'h73: dec.cyc = CIT_CYC_JUMP_IND;
			8'h22, 8'h32: dec.cyc = CIT_CYC_RETURN;
			8'hC6, 8'hC7, 8'hD6, 8'hD7: dec.cyc = CIT_CYC_SWAP_IND;
			8'h40, 8'h50, 8'h60, 8'h70: dec.cond = 1'b1;
			8'h10, 8'h20, 8'h30: dec.cond = 1'b1;
			8'hB4, 8'hB5, [8'hB8:8'hBF]: dec.cond = 1'b1;
			8'hB6, 8'hB7: begin
				dec.cond = 1'b1;
				dec.cyc = CIT_CYC_CMP_IND;
			end
			8'hD5, [8'hD8:8'hDF]: dec.cond = 1'b1;
			default: dec.cond = 1'b0;
		endcase
	end
endmodule

// ### logic/cit_debug_ctl.sv
// Debug control: breakpoints, halt, run and single step
`timescale 1ns/10ps
module cit_debug_ctl
	import cit_pkg::*;
#(
	parameter int NUM_BP = 4
) (
	input wire logic clk,
	input wire logic reset,
	cit_dbg_if.ctl dbg
);
	typedef struct packed {
		logic halted;
		logic step_pend;
		logic skip;
		logic at_bp;
		logic [NUM_BP-1:0] bp_en;
		logic [NUM_BP-1:0][15:0] bp_addr;
	} cit_dbg_state_t;

	cit_dbg_state_t cur_ff;
	cit_dbg_state_t nxt_state;
	logic hit;

	// Breakpoints compare in private flops, nothing the program can see
	always_comb begin
		hit = 1'b0;
		for (int i = 0; i < NUM_BP; i++) begin
			if (cur_ff.bp_en[i] && cur_ff.bp_addr[i] == dbg.fetch_addr) begin
				hit = 1'b1;
			end
		end
		hit = hit && dbg.fetch_valid && !cur_ff.skip && !cur_ff.halted;
		dbg.bp_hit = hit;
		dbg.halted = cur_ff.halted;
		dbg.permit = (!cur_ff.halted || cur_ff.step_pend) && !hit;
		nxt_state = cur_ff;
		if (dbg.accept) begin
			nxt_state.skip = 1'b0;
			nxt_state.at_bp = 1'b0;
			if (cur_ff.step_pend) begin
				nxt_state.step_pend = 1'b0;
				nxt_state.halted = 1'b1;
			end
		end
		if (hit || dbg.halt_req) begin
			nxt_state.halted = 1'b1;
		end
		if (hit) begin
			nxt_state.at_bp = 1'b1;
		end
		// Skip only after a breakpoint stop, so a breakpoint set while halted still fires
		// Step completion wins over a run pulse in the same cycle
		if (dbg.run_req && cur_ff.halted && !dbg.halt_req && !(dbg.accept && cur_ff.step_pend)) begin
			nxt_state.halted = 1'b0;
			nxt_state.skip = cur_ff.at_bp;
		end
		if (dbg.step_req && cur_ff.halted && !cur_ff.step_pend) begin
			nxt_state.step_pend = 1'b1;
			nxt_state.skip = cur_ff.at_bp;
		end
		if (dbg.bp_wr) begin
			nxt_state.bp_addr[dbg.bp_index] = dbg.bp_addr;
			nxt_state.bp_en[dbg.bp_index] = dbg.bp_enable;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_state;
		end
	end
endmodule

// ### logic/cit_core_timing.sv
// Top: instruction cycle sequencer, stack pointer and debug hooks
`timescale 1ns/10ps
//
// Summary of operation
// - Opcodes, addressing, flag effects match standard set
// - All timing counted in single clock cycles
// - Most instructions: cycles equal program bytes
// - Untaken conditional branch one cycle shorter
// - Swap timing: register 1, direct 2, indirect 2
// - Carry ops one cycle; direct bit ops two
// - Carry and accumulator jumps take 2/3 cycles
// - Bit jumps 3/4; set-then-clear clears bit
// - Absolute and short jumps 3, long 4
// - Indirect jump: one byte, three cycles
// - Compare-jump direct/immediate forms take 3/4
// - Compare-jump on indirect operand takes 4/5
// - Decrement-jump-nonzero on register takes 2/3 cycles, on direct 3/4
// - Stack pointer increments before each push store
// - Stack pointer resets to 0x07
// - Debugger breakpoints, run, halt, step, register access
// - Debug uses no program-visible resources
//
module cit_core_timing
	import cit_pkg::*;
#(
	parameter int NUM_BP = CIT_NUM_BP,
	parameter int CNT_W = CIT_CNT_W,
	parameter int IDX_W = (NUM_BP > 1) ? $clog2(NUM_BP) : 1
) (
	input wire logic clk,
	input wire logic reset,
	// Instruction issue from the fetch stage
	input wire logic instr_valid,
	input wire logic [7:0] instr_opcode,
	input wire logic [15:0] instr_addr,
	input wire logic branch_cond,
	output logic instr_ready,
	// Retirement report
	output logic retire_pulse,
	output logic [1:0] retire_len,
	output logic [2:0] retire_cycles,
	output logic retire_taken,
	output logic clear_tested_bit,
	// Stack access from the datapath
	input wire logic push_req,
	input wire logic pop_req,
	output logic stack_wr,
	output logic stack_rd,
	output logic [7:0] stack_addr,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	// Debug link side
	input wire logic dbg_halt_req,
	input wire logic dbg_run_req,
	input wire logic dbg_step_req,
	input wire logic dbg_bp_wr,
	input wire logic [IDX_W-1:0] dbg_bp_index,
	input wire logic [15:0] dbg_bp_addr,
	input wire logic dbg_bp_enable,
	input wire logic dbg_sp_wr,
	input wire logic [7:0] dbg_sp_wdata,
	output logic [7:0] dbg_sp_rdata,
	output logic dbg_halted,
	output logic dbg_bp_hit,
	output logic [15:0] dbg_last_addr,
	output logic [CNT_W-1:0] dbg_cycle_count,
	output logic [CNT_W-1:0] dbg_instr_count
);
	typedef struct packed {
		cit_cyc_t rem;
		cit_len_t len;
		cit_cyc_t cyc;
		logic taken;
		logic bit_clear;
		logic retire;
		logic clear_bit;
		logic [7:0] stack_pointer;
		logic stk_wr;
		logic stk_rd;
		logic [7:0] stk_addr;
		logic [7:0] rdata;
		logic rvalid;
		logic [7:0] dbg_sp;
		logic [15:0] last_addr;
		logic [CNT_W-1:0] cyc_cnt;
		logic [CNT_W-1:0] instr_cnt;
	} cit_core_state_t;

	cit_core_state_t cur_ff;
	cit_core_state_t nxt_state;

	logic idle;
	logic accept;
	logic took;
	cit_cyc_t total;
	logic [7:0] sp_inc;
	logic [7:0] sp_dec;

	cit_dec_if dec_link();
	cit_dbg_if #(.NUM_BP(NUM_BP), .IDX_W(IDX_W)) dbg_link();

	cit_opcode_decode u_decode (
		.dec(dec_link)
	);

	cit_debug_ctl #(
		.NUM_BP(NUM_BP)
	) u_debug (
		.clk(clk),
		.reset(reset),
		.dbg(dbg_link)
	);

	// Issue handshake
	always_comb begin
		idle = (cur_ff.rem == 3'h0);
		instr_ready = idle && dbg_link.permit;
		accept = instr_valid && instr_ready;
	end

	always_comb begin
		dec_link.opcode = instr_opcode;
		// Condition is sampled in the issue cycle
		took = dec_link.cond && branch_cond;
		total = cit_total(dec_link.cyc, took);
	end

	always_comb begin
		dbg_link.halt_req = dbg_halt_req;
		dbg_link.run_req = dbg_run_req;
		dbg_link.step_req = dbg_step_req;
		dbg_link.bp_wr = dbg_bp_wr;
		dbg_link.bp_index = dbg_bp_index;
		dbg_link.bp_addr = dbg_bp_addr;
		dbg_link.bp_enable = dbg_bp_enable;
		dbg_link.fetch_valid = instr_valid && idle;
		dbg_link.fetch_addr = instr_addr;
		dbg_link.accept = accept;
	end

	always_comb begin
		sp_inc = cur_ff.stack_pointer + 8'h01;
		sp_dec = cur_ff.stack_pointer - 8'h01;
	end

	always_comb begin
		nxt_state = cur_ff;
		nxt_state.retire = 1'b0;
		nxt_state.clear_bit = 1'b0;
		nxt_state.stk_wr = 1'b0;
		nxt_state.stk_rd = 1'b0;
		nxt_state.rvalid = 1'b0;

		// Sequencer counts whole clocks, one per edge
		if (accept) begin
			nxt_state.len = dec_link.len;
			nxt_state.cyc = total;
			nxt_state.taken = took;
			nxt_state.bit_clear = dec_link.bit_clear;
			nxt_state.last_addr = instr_addr;
			nxt_state.instr_cnt = cur_ff.instr_cnt + CNT_W'(1);
			nxt_state.rem = cit_cyc_t'(total - 3'h1);
			if (total == 3'h1) begin
				nxt_state.retire = 1'b1;
			end
		end else if (!idle) begin
			nxt_state.rem = cit_cyc_t'(cur_ff.rem - 3'h1);
			if (cur_ff.rem == 3'h1) begin
				nxt_state.retire = 1'b1;
				// Tested bit cleared only when the jump goes
				nxt_state.clear_bit = cur_ff.taken && cur_ff.bit_clear;
			end
		end

		// Clock count runs while the core is not stopped
		if (!dbg_link.halted || !idle) begin
			nxt_state.cyc_cnt = cur_ff.cyc_cnt + CNT_W'(1);
		end

		// Stack pointer: debugger write, then program write, then push or pop
		if (dbg_sp_wr && dbg_link.halted) begin
			nxt_state.stack_pointer = dbg_sp_wdata;
		end else if (sfr_wr && sfr_addr == CIT_SP_ADDR) begin
			nxt_state.stack_pointer = sfr_wdata;
		end else if (push_req) begin
			nxt_state.stack_pointer = sp_inc;
			nxt_state.stk_addr = sp_inc;
			nxt_state.stk_wr = 1'b1;
		end else if (pop_req) begin
			nxt_state.stk_addr = cur_ff.stack_pointer;
			nxt_state.stk_rd = 1'b1;
			nxt_state.stack_pointer = sp_dec;
		end

		// Other SFR addresses belong to other blocks; read as zero here
		if (sfr_rd) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata = (sfr_addr == CIT_SP_ADDR) ? cur_ff.stack_pointer : 8'h00;
		end

		// Debug readout is a private copy, not a program register
		nxt_state.dbg_sp = nxt_state.stack_pointer;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur_ff <= '0;
			cur_ff.stack_pointer <= CIT_SP_RESET;
			cur_ff.dbg_sp <= CIT_SP_RESET;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	always_comb begin
		retire_pulse = cur_ff.retire;
		retire_len = cur_ff.len;
		retire_cycles = cur_ff.cyc;
		retire_taken = cur_ff.taken;
		clear_tested_bit = cur_ff.clear_bit;
		stack_wr = cur_ff.stk_wr;
		stack_rd = cur_ff.stk_rd;
		stack_addr = cur_ff.stk_addr;
		sfr_rdata = cur_ff.rdata;
		sfr_rvalid = cur_ff.rvalid;
		dbg_sp_rdata = cur_ff.dbg_sp;
		dbg_halted = dbg_link.halted;
		dbg_bp_hit = dbg_link.bp_hit;
		dbg_last_addr = cur_ff.last_addr;
		dbg_cycle_count = cur_ff.cyc_cnt;
		dbg_instr_count = cur_ff.instr_cnt;
	end
endmodule

// ### testbench/cit_core_timing_assertions.sv
// Checker: retire timing, stack pointer and register port relations
`timescale 1ns/10ps
module cit_core_timing_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [7:0] instr_opcode,
	input wire logic branch_cond,
	input wire logic instr_ready,
	input wire logic retire_pulse,
	input wire logic [1:0] retire_len,
	input wire logic [2:0] retire_cycles,
	input wire logic retire_taken,
	input wire logic clear_tested_bit,
	input wire logic push_req,
	input wire logic stack_wr,
	input wire logic [7:0] stack_addr,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_rvalid,
	input wire logic dbg_sp_wr,
	input wire logic [7:0] dbg_sp_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic acc;
	assign acc = instr_valid && instr_ready;
	chk_sp_reset_value: assert property ($fell(reset) |-> dbg_sp_rdata == 8'h07)
		else $error("stack pointer not at reset value");
	chk_push_pre_incr: assert property (push_req && !sfr_wr && !dbg_sp_wr |=>
		stack_wr && stack_addr == $past(dbg_sp_rdata) + 8'h01) else $error("push not pre-incremented");
	chk_sfr_sp_read: assert property (sfr_rd && sfr_addr == 8'h81 |=>
		sfr_rvalid && sfr_rdata == $past(dbg_sp_rdata)) else $error("stack pointer read wrong");
	chk_carry_jump_taken: assert property (acc && instr_opcode == 8'h40 && branch_cond |=>
		!instr_ready [*2] ##1 retire_pulse && retire_cycles == 3'h3 && retire_taken)
		else $error("taken carry jump timing wrong");
	chk_carry_jump_short: assert property (acc && instr_opcode == 8'h40 && !branch_cond |=>
		!retire_pulse ##1 retire_pulse && retire_cycles == 3'h2) else $error("untaken jump not shorter");
	chk_cmp_ind_untaken: assert property (acc && instr_opcode == 8'hB6 && !branch_cond |->
		##4 retire_pulse && retire_cycles == 3'h4) else $error("indirect compare timing wrong");
	chk_ind_jump_three: assert property (acc && instr_opcode == 8'h73 |->
		##3 retire_pulse && retire_len == 2'h1 && retire_cycles == 3'h3) else $error("indirect jump timing wrong");
	chk_carry_op_one: assert property (acc && instr_opcode == 8'hC3 |=>
		retire_pulse && retire_len == 2'h1 && retire_cycles == 3'h1) else $error("carry op not one cycle");
	chk_bit_clear_taken: assert property (clear_tested_bit |-> retire_pulse && retire_taken)
		else $error("tested bit cleared without taken jump");
endmodule
bind cit_core_timing cit_core_timing_chk i_chk (.clk, .reset, .instr_valid, .instr_opcode, .branch_cond,
	.instr_ready, .retire_pulse, .retire_len, .retire_cycles, .retire_taken, .clear_tested_bit, .push_req,
	.stack_wr, .stack_addr, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rdata, .sfr_rvalid, .dbg_sp_wr, .dbg_sp_rdata);

// ### testbench/cit_debugger_model.sv
// Debugger model: run, halt, step, breakpoint and stack pointer writes
`timescale 1ns/10ps
module cit_debugger_model (
	input wire logic clk,
	output logic halt_req,
	output logic run_req,
	output logic step_req,
	output logic bp_wr,
	output logic [1:0] bp_index,
	output logic [15:0] bp_addr,
	output logic bp_enable,
	output logic sp_wr,
	output logic [7:0] sp_wdata
);
	initial begin
		{halt_req, run_req, step_req, bp_wr, bp_index, bp_addr, bp_enable, sp_wr, sp_wdata} = '0;
	end
	// One-cycle pulse of {halt, run, step}
	task automatic ctl(input logic [2:0] hrs);
		@(negedge clk);
		{halt_req, run_req, step_req} = hrs;
		@(negedge clk);
		{halt_req, run_req, step_req} = 3'h0;
	endtask
	task automatic bp(input logic [1:0] idx, input logic [15:0] a);
		@(negedge clk);
		{bp_wr, bp_index, bp_addr, bp_enable} = {1'h1, idx, a, 1'h1};
		@(negedge clk);
		bp_wr = 1'h0;
		bp_addr = ~bp_addr;
	endtask
	task automatic sp_write(input logic [7:0] v);
		@(negedge clk);
		{sp_wr, sp_wdata} = {1'h1, v};
		@(negedge clk);
		sp_wr = 1'h0;
		sp_wdata = ~sp_wdata;
	endtask
endmodule

// ### testbench/tb_cpu_instruction_cycle_timing.sv
// Testbench: instruction timing, stack pointer and debug control
`timescale 1ns/10ps
module tb_cpu_instruction_cycle_timing;
	import cit_pkg::*;
	logic clk, reset, instr_valid, branch_cond, instr_ready, push_req, pop_req, stack_wr, stack_rd;
	logic retire_pulse, retire_taken, clear_tested_bit, sfr_wr, sfr_rd, sfr_rvalid, dbg_halted, dbg_bp_hit;
	logic dbg_halt_req, dbg_run_req, dbg_step_req, dbg_bp_wr, dbg_bp_enable, dbg_sp_wr;
	logic [1:0] retire_len, dbg_bp_index;
	logic [2:0] retire_cycles;
	logic [7:0] instr_opcode, stack_addr, sfr_addr, sfr_wdata, sfr_rdata, dbg_sp_wdata, dbg_sp_rdata, sp;
	logic [15:0] instr_addr, dbg_bp_addr, dbg_last_addr;
	logic [31:0] dbg_cycle_count, dbg_instr_count, cc;
	logic [31:0] r;
	logic [5:0] q_ret[$];
	logic [7:0] q_stk[$], q_sfr[$];
	integer seed;
	int fail_count, cmp_count;
	// Opcode, byte length, conditional flag in bit 3, base cycles
	localparam logic [15:0] OPS [0:21] = '{16'hC811, 16'hC522, 16'hC612, 16'hD612, 16'hC311, 16'hC222,
		16'h8222, 16'hA222, 16'h402A, 16'h502A, 16'h203B, 16'h103B, 16'h1123, 16'h1234, 16'h8023,
		16'h0234, 16'h7313, 16'h602A, 16'hB43B, 16'hB83B, 16'hB63C, 16'hD82A};
	cit_core_timing i_dut (.clk, .reset, .instr_valid, .instr_opcode, .instr_addr, .branch_cond, .instr_ready,
		.retire_pulse, .retire_len, .retire_cycles, .retire_taken, .clear_tested_bit, .push_req, .pop_req,
		.stack_wr, .stack_rd, .stack_addr, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_rvalid,
		.dbg_halt_req, .dbg_run_req, .dbg_step_req, .dbg_bp_wr, .dbg_bp_index, .dbg_bp_addr, .dbg_bp_enable,
		.dbg_sp_wr, .dbg_sp_wdata, .dbg_sp_rdata, .dbg_halted, .dbg_bp_hit, .dbg_last_addr,
		.dbg_cycle_count, .dbg_instr_count);
	cit_debugger_model dbm (.clk, .halt_req(dbg_halt_req), .run_req(dbg_run_req), .step_req(dbg_step_req),
		.bp_wr(dbg_bp_wr), .bp_index(dbg_bp_index), .bp_addr(dbg_bp_addr), .bp_enable(dbg_bp_enable),
		.sp_wr(dbg_sp_wr), .sp_wdata(dbg_sp_wdata));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic issue(input logic [15:0] e, input logic c, input logic [15:0] a);
		int n;
		n = 0;
		@(negedge clk);
		{instr_valid, instr_opcode, branch_cond, instr_addr} = {1'h1, e[15:8], c, a};
		while (!instr_ready && n < 30) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		if (n >= 30) fail_count++;
		q_ret.push_back({e[15:8] == 8'h10 && c, e[5:4], e[2:0] + {2'h0, e[3] & c}});
	endtask
	task automatic stk(input logic p);
		@(negedge clk);
		{push_req, pop_req} = {p, !p};
		if (p) sp++;
		q_stk.push_back(sp);
		if (!p) sp--;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		{sfr_rd, sfr_addr} = {1'h1, a};
		q_sfr.push_back(a == 8'h81 ? sp : 8'h00);
		@(negedge clk);
		sfr_rd = 1'h0;
	endtask
	always @(negedge clk) if (!reset) begin
		if (retire_pulse) chk({clear_tested_bit, retire_len, retire_cycles}, q_ret.pop_front());
		if (stack_wr || stack_rd) chk(stack_addr, q_stk.pop_front());
		if (sfr_rvalid) chk(sfr_rdata, q_sfr.pop_front());
	end
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		seed = 32'hd1db_d5a4;
		{reset, instr_valid, branch_cond, push_req, pop_req, sfr_wr, sfr_rd} = 7'h01 << 6;
		{instr_opcode, instr_addr, sfr_addr, sfr_wdata} = '0;
		sp = 8'h07;
		repeat (5) @(posedge clk);
		@(negedge clk);
		reset = 1'h0;
		rd(8'h81);
		rd(8'h80);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			stk(r[0]);
		end
		@(negedge clk);
		{push_req, pop_req, sfr_wr, sfr_addr, sfr_wdata} = {3'h1, 8'h81, r[15:8]};
		sp = r[15:8];
		@(negedge clk);
		sfr_wr = 1'h0;
		rd(8'h81);
		for (int j = 0; j < 2; j++) begin
			foreach (OPS[i]) begin
				r = $random(seed);
				issue(OPS[i], j[0], r[15:0]);
			end
		end
		@(negedge clk);
		instr_valid = 1'h0;
		repeat (8) @(negedge clk);
		dbm.ctl(3'h4);
		chk(dbg_halted, 1'h1);
		chk(instr_ready, 1'h0);
		cc = dbg_cycle_count;
		dbm.sp_write(8'h3C);
		sp = 8'h3C;
		rd(8'h81);
		chk(dbg_cycle_count[15:0], cc[15:0]);
		dbm.ctl(3'h1);
		issue(OPS[4], 1'h0, 16'h0100);
		@(negedge clk);
		instr_valid = 1'h0;
		repeat (3) @(negedge clk);
		chk(dbg_halted, 1'h1);
		dbm.bp(2'h0, 16'h0200);
		dbm.ctl(3'h2);
		@(negedge clk);
		{instr_valid, instr_addr} = {1'h1, 16'h0200};
		#1;
		chk({dbg_bp_hit, instr_ready}, 2'h2);
		@(negedge clk);
		instr_valid = 1'h0;
		chk(dbg_halted, 1'h1);
		dbm.ctl(3'h2);
		issue(OPS[4], 1'h0, 16'h0200);
		@(negedge clk);
		instr_valid = 1'h0;
		repeat (4) @(negedge clk);
		chk(dbg_halted, 1'h0);
		chk(dbg_last_addr, 16'h0200);
		chk(dbg_instr_count[15:0], 16'h002e);
		tally_and_finish();
	end
endmodule
